// [tpm_state_gate.sv]
// operating state tracker and command admission gate
//
// Function
// - enter update mode only after verified signature
// - import update data only when verified
// - leave update mode after final good block
// - init state admits only listed commands
// - resume or restart in init goes operational
// - init clear startup resets, state startup without saved state fails
// - operational refuses startup, checks access otherwise
// - self-test entry from operational; refuse others
// - self-test exits on result: pass or fail
// - fail state runs test-result and capability only
// - init indication returns fail to init
// - shutdown for all; state type saves
// - untested function during tests answers testing
// - reject modified, missing, inserted, replayed blocks
// - clock set below current rejected
// - clock set above maximum rejected
// - persistence and clock need platform or owner
// - anyone reads clock and counters
// - sign needs key auth and attribute
// - encrypt open; decrypt, zgen need auth
// - hash start open; other sequence steps need user in operational state, open in init
// - verify, random, keygen, params, hash open
// - failed restore enters fail with failure
// - power-on tests before first command
`timescale 1ns/1ps
`default_nettype none
module tpm_state_gate
    import tpm_gate_pkg::*;
#(
    parameter int SEQ_W = 16
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic cmd_valid_i,
    input wire cmd_e cmd_code_i,
    input wire logic cmd_su_type_i,
    input wire logic cmd_untested_i,
    input wire logic sess_load_i,
    input wire logic [ROLE_W-1:0] sess_roles_i,
    input wire logic pp_req_i,
    input wire logic pp_i,
    input wire logic key_sign_ext_i,
    input wire logic key_enc_ext_i,
    input wire logic key_dec_ext_i,
    input wire logic [CLK_W-1:0] clk_new_i,
    input wire logic [CLK_W-1:0] clk_cur_i,
    input wire logic fw_sig_ok_i,
    input wire logic [SEQ_W-1:0] fw_seq_i,
    input wire logic fw_mac_ok_i,
    input wire logic fw_last_i,
    input wire logic restore_ok_i,
    input wire logic init_ind_i,
    input wire logic st_done_i,
    input wire logic st_pass_i,
    output logic rsp_valid_o,
    output logic [RC_W-1:0] rsp_code_o,
    output logic exec_o,
    output gate_state_e state_o,
    output logic st_start_o,
    output logic opvar_reset_o,
    output logic saved_valid_o,
    output logic fw_import_o,
    output logic [ROLE_W-1:0] sess_roles_o
);

    gate_state_e state_r, state_nxt;
    logic post_busy_r, post_kick_r, saved_valid_r;
    logic [ROLE_W-1:0] sess_r;
    logic grant, go_test, go_post, op_reset, save_set, save_clr, fw_start, fw_blk;
    logic [RC_W-1:0] rc, acc;
    logic blk_ok, blk_done, is_test_cmd;

    // commands admitted in init for any caller
    function automatic logic init_allowed(input cmd_e c);
        unique case (c)
            CMD_HASH_SEQ_START, CMD_SEQ_UPDATE, CMD_EVENT_SEQ_COMPLETE, CMD_SEQ_COMPLETE,
            CMD_PCR_EXTEND, CMD_STARTUP, CMD_SELF_TEST, CMD_GET_RANDOM,
            CMD_HIER_CONTROL, CMD_HIER_CHANGE_AUTH, CMD_SET_PRIMARY_POLICY,
            CMD_GET_CAP, CMD_NV_READ, CMD_HASH_IND, CMD_SHUTDOWN: init_allowed = 1'b1;
            default: init_allowed = 1'b0;
        endcase
    endfunction : init_allowed

    // operational role and attribute check
    function automatic logic [RC_W-1:0] access_rc(input cmd_e c, input logic [ROLE_W-1:0] r,
                                                  input logic ppq, input logic pp,
                                                  input logic a_sign, input logic a_enc,
                                                  input logic a_dec);
        logic plat_ok;
        plat_ok = r[ROLE_PLAT] && (!ppq || pp);
        access_rc = RC_SUCCESS;
        unique case (c)
            CMD_EVICT_CONTROL, CMD_CLOCK_SET, CMD_CLOCK_RATE_ADJ: begin
                if (!(plat_ok || r[ROLE_OWNER])) access_rc = RC_AUTH_FAIL;
            end
            CMD_SIGN: begin
                if (!r[ROLE_USER]) access_rc = RC_AUTH_FAIL;
                else if (!a_sign) access_rc = RC_ATTRIBUTES;
            end
            CMD_RSA_ENC: begin
                if (!a_enc) access_rc = RC_ATTRIBUTES;
            end
            CMD_RSA_DEC: begin
                if (!r[ROLE_USER]) access_rc = RC_AUTH_FAIL;
                else if (!a_dec) access_rc = RC_ATTRIBUTES;
            end
            CMD_ECDH_ZGEN, CMD_HMAC_START, CMD_SEQ_UPDATE, CMD_SEQ_COMPLETE,
            CMD_EVENT_SEQ_COMPLETE: begin
                if (!r[ROLE_USER]) access_rc = RC_AUTH_FAIL;
            end
            // open to any caller
            CMD_READ_CLOCK, CMD_HASH_SEQ_START, CMD_VERIFY_SIG, CMD_GET_RANDOM,
            CMD_STIR_RANDOM, CMD_ECDH_KEYGEN, CMD_ECC_PARAMS, CMD_HASH: begin
                access_rc = RC_SUCCESS;
            end
            default: access_rc = RC_SUCCESS;
        endcase
    endfunction : access_rc

    assign is_test_cmd = (cmd_code_i == CMD_SELF_TEST) || (cmd_code_i == CMD_INCR_SELF_TEST);

    fw_block_check #(
        .SEQ_W(SEQ_W)
    ) u_fw_check (
        .clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .start_i(fw_start),
        .blk_valid_i(fw_blk),
        .seq_i(fw_seq_i),
        .mac_ok_i(fw_mac_ok_i),
        .last_i(fw_last_i),
        .blk_ok_o(blk_ok),
        .blk_done_o(blk_done)
    );

    // command decision and next state
    always_comb begin
        grant = 1'b0;
        rc = RC_SUCCESS;
        state_nxt = state_r;
        go_test = 1'b0;
        go_post = 1'b0;
        op_reset = 1'b0;
        save_set = 1'b0;
        save_clr = 1'b0;
        fw_start = 1'b0;
        fw_blk = 1'b0;
        acc = access_rc(cmd_code_i, sess_r, pp_req_i, pp_i, key_sign_ext_i, key_enc_ext_i,
                        key_dec_ext_i);
        if (init_ind_i) begin
            state_nxt = ST_INIT;
            rc = RC_INITIALIZE;
        end else if (cmd_valid_i && post_busy_r) begin
            rc = RC_TESTING;
        end else if (cmd_valid_i) begin
            unique case (state_r)
                ST_INIT: begin
                    if (cmd_code_i == CMD_STARTUP) begin
                        save_clr = 1'b1;
                        if (saved_valid_r && cmd_su_type_i == SU_STATE) begin
                            if (restore_ok_i) begin
                                grant = 1'b1;
                                state_nxt = ST_OPER;
                            end else begin
                                rc = RC_FAILURE;
                                state_nxt = ST_FAIL;
                            end
                        end else if (cmd_su_type_i == SU_CLEAR) begin
                            grant = 1'b1;
                            op_reset = 1'b1;
                            state_nxt = ST_OPER;
                        end else begin
                            rc = RC_FAILURE;
                            save_clr = 1'b0;
                        end
                    end else if (init_allowed(cmd_code_i)) begin
                        grant = 1'b1;
                        go_post = (cmd_code_i == CMD_SELF_TEST);
                        save_set = (cmd_code_i == CMD_SHUTDOWN) && (cmd_su_type_i == SU_STATE);
                    end else begin
                        rc = RC_INITIALIZE;
                    end
                end
                ST_OPER: begin
                    if (cmd_code_i == CMD_STARTUP) begin
                        rc = RC_INITIALIZE;
                    end else if (cmd_untested_i && !is_test_cmd) begin
                        rc = RC_TESTING;
                        go_test = 1'b1;
                        state_nxt = ST_SELFTEST;
                    end else if (is_test_cmd) begin
                        grant = 1'b1;
                        go_test = 1'b1;
                        state_nxt = ST_SELFTEST;
                    end else if (cmd_code_i == CMD_FW_START) begin
                        if (sess_r[ROLE_PLAT] && fw_sig_ok_i) begin
                            grant = 1'b1;
                            fw_start = 1'b1;
                            state_nxt = ST_FWUPD;
                        end else begin
                            rc = RC_AUTH_FAIL;
                        end
                    end else if (cmd_code_i == CMD_FW_DATA) begin
                        rc = RC_FAILURE;
                    end else if (acc != RC_SUCCESS) begin
                        rc = acc;
                    end else if (cmd_code_i == CMD_CLOCK_SET && clk_new_i < clk_cur_i) begin
                        rc = RC_VALUE;
                    end else if (cmd_code_i == CMD_CLOCK_SET && clk_new_i > CLK_MAX) begin
                        rc = RC_VALUE;
                    end else begin
                        grant = 1'b1;
                        save_set = (cmd_code_i == CMD_SHUTDOWN) && (cmd_su_type_i == SU_STATE);
                    end
                end
                ST_SELFTEST: begin
                    rc = RC_TESTING;
                end
                ST_FAIL: begin
                    if (cmd_code_i == CMD_GET_TEST_RESULT || cmd_code_i == CMD_GET_CAP) begin
                        grant = 1'b1;
                    end else begin
                        rc = RC_FAILURE;
                    end
                end
                ST_FWUPD: begin
                    if (cmd_code_i == CMD_FW_DATA) begin
                        fw_blk = 1'b1;
                        if (blk_ok) begin
                            grant = 1'b1;
                            if (blk_done) state_nxt = ST_INIT;
                        end else begin
                            rc = RC_INTEGRITY;
                        end
                    end else begin
                        rc = RC_FAILURE;
                    end
                end
            endcase
        end
        if (!init_ind_i && st_done_i) begin
            if (state_r == ST_SELFTEST) begin
                state_nxt = st_pass_i ? ST_OPER : ST_FAIL;
            end else if (post_busy_r && !st_pass_i) begin
                state_nxt = ST_FAIL;
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= ST_INIT;
        end else begin
            state_r <= state_nxt;
        end
    end

    // power-on and init test tracking
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            post_kick_r <= 1'b1;
            post_busy_r <= 1'b1;
            st_start_o <= 1'b0;
        end else begin
            post_kick_r <= 1'b0;
            st_start_o <= post_kick_r || init_ind_i || go_test || go_post;
            if (init_ind_i || go_post) begin
                post_busy_r <= 1'b1;
            end else if (st_done_i) begin
                post_busy_r <= 1'b0;
            end
        end
    end

    // saved shutdown state
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            saved_valid_r <= 1'b0;
        end else if (save_set) begin
            saved_valid_r <= 1'b1;
        end else if (save_clr) begin
            saved_valid_r <= 1'b0;
        end
    end

    // session authorization status
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sess_r <= ROLES_RST;
        end else if (init_ind_i || op_reset) begin
            sess_r <= ROLES_RST;
        end else if (sess_load_i) begin
            sess_r <= sess_roles_i;
        end
    end

    // response outputs
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rsp_valid_o <= 1'b0;
            rsp_code_o <= RC_SUCCESS;
            exec_o <= 1'b0;
            opvar_reset_o <= 1'b0;
            fw_import_o <= 1'b0;
        end else begin
            rsp_valid_o <= cmd_valid_i;
            rsp_code_o <= cmd_valid_i ? rc : RC_SUCCESS;
            exec_o <= cmd_valid_i && grant;
            opvar_reset_o <= op_reset;
            fw_import_o <= fw_blk && blk_ok;
        end
    end

    assign state_o = state_r;
    assign saved_valid_o = saved_valid_r;
    assign sess_roles_o = sess_r;

    AST_OPER_STARTUP: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (cmd_valid_i && state_r == ST_OPER && cmd_code_i == CMD_STARTUP && !init_ind_i && !post_busy_r)
        |=> (rsp_code_o == RC_INITIALIZE && !exec_o && state_r == ST_OPER))
        else $error("startup ran in operational state");
    AST_SELFTEST_REFUSE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (cmd_valid_i && state_r == ST_SELFTEST && !init_ind_i) |=> (!exec_o && rsp_code_o == RC_TESTING))
        else $error("command ran during self-test");
    AST_SELFTEST_EXIT: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_r == ST_SELFTEST && st_done_i && !init_ind_i)
        |=> (state_r == ($past(st_pass_i) ? ST_OPER : ST_FAIL)))
        else $error("wrong exit from self-test");
    AST_SELFTEST_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_r == ST_SELFTEST && !st_done_i && !init_ind_i) |=> (state_r == ST_SELFTEST))
        else $error("left self-test before result");
    AST_FAIL_ONLY: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (exec_o && $past(state_r) == ST_FAIL)
        |-> ($past(cmd_code_i) == CMD_GET_TEST_RESULT || $past(cmd_code_i) == CMD_GET_CAP))
        else $error("disallowed command ran in fail state");
    AST_INIT_IND: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        init_ind_i |=> (state_r == ST_INIT && st_start_o))
        else $error("init indication did not return to init");
    AST_CLOCK_LOW: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (cmd_valid_i && cmd_code_i == CMD_CLOCK_SET && clk_new_i < clk_cur_i) |=> !exec_o)
        else $error("clock set below current value");
    AST_CLOCK_MAX: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (cmd_valid_i && cmd_code_i == CMD_CLOCK_SET && clk_new_i > CLK_MAX) |=> !exec_o)
        else $error("clock set above maximum");
    AST_CLOCK_AUTH: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (cmd_valid_i && cmd_code_i == CMD_CLOCK_SET && !sess_r[ROLE_OWNER] && !sess_r[ROLE_PLAT])
        |=> !exec_o)
        else $error("clock set without platform or owner");
    AST_RESTORE_FAIL: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (cmd_valid_i && !init_ind_i && !post_busy_r && !st_done_i && state_r == ST_INIT
         && cmd_code_i == CMD_STARTUP && saved_valid_r && cmd_su_type_i == SU_STATE && !restore_ok_i)
        |=> (state_r == ST_FAIL && rsp_code_o == RC_FAILURE))
        else $error("failed restore did not enter fail");
    AST_POST_BLOCK: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (cmd_valid_i && post_busy_r && !init_ind_i) |=> (!exec_o && rsp_code_o == RC_TESTING))
        else $error("command ran before power-on tests finished");
    AST_FW_ENTRY: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_r != ST_FWUPD ##1 state_r == ST_FWUPD) |-> $past(fw_sig_ok_i) && $past(sess_r[ROLE_PLAT]))
        else $error("update mode entered without verified signature");

endmodule : tpm_state_gate
`default_nettype wire

// [tpm_gate_pkg.sv]
// shared constants and types for the module state and command gate
package tpm_gate_pkg;

    typedef enum logic [2:0] {
        ST_INIT,
        ST_OPER,
        ST_SELFTEST,
        ST_FAIL,
        ST_FWUPD
    } gate_state_e;

    typedef enum logic [5:0] {
        CMD_HASH_SEQ_START, CMD_SEQ_UPDATE, CMD_EVENT_SEQ_COMPLETE, CMD_SEQ_COMPLETE,
        CMD_PCR_EXTEND, CMD_STARTUP, CMD_SELF_TEST, CMD_INCR_SELF_TEST,
        CMD_GET_RANDOM, CMD_HIER_CONTROL, CMD_HIER_CHANGE_AUTH, CMD_SET_PRIMARY_POLICY,
        CMD_GET_CAP, CMD_NV_READ, CMD_HASH_IND, CMD_SHUTDOWN,
        CMD_GET_TEST_RESULT, CMD_EVICT_CONTROL, CMD_CLOCK_SET, CMD_CLOCK_RATE_ADJ,
        CMD_READ_CLOCK, CMD_SIGN, CMD_VERIFY_SIG, CMD_STIR_RANDOM,
        CMD_RSA_ENC, CMD_RSA_DEC, CMD_ECDH_KEYGEN, CMD_ECDH_ZGEN,
        CMD_ECC_PARAMS, CMD_HMAC_START, CMD_HASH, CMD_FW_START,
        CMD_FW_DATA, CMD_OTHER
    } cmd_e;

    // session role bits
    localparam int ROLE_W = 3;
    localparam int ROLE_PLAT = 0;
    localparam int ROLE_OWNER = 1;
    localparam int ROLE_USER = 2;
    localparam logic [ROLE_W-1:0] ROLES_RST = 3'h0;

    // startup and shutdown type
    localparam logic SU_CLEAR = 1'h0;
    localparam logic SU_STATE = 1'h1;

    // response codes
    localparam int RC_W = 8;
    localparam logic [RC_W-1:0] RC_SUCCESS = 8'h00;
    localparam logic [RC_W-1:0] RC_FAILURE = 8'h01;
    localparam logic [RC_W-1:0] RC_TESTING = 8'h02;
    localparam logic [RC_W-1:0] RC_INITIALIZE = 8'h03;
    localparam logic [RC_W-1:0] RC_AUTH_FAIL = 8'h04;
    localparam logic [RC_W-1:0] RC_ATTRIBUTES = 8'h05;
    localparam logic [RC_W-1:0] RC_VALUE = 8'h06;
    localparam logic [RC_W-1:0] RC_INTEGRITY = 8'h07;

    // clock limit
    localparam int CLK_W = 64;
    localparam logic [CLK_W-1:0] CLK_MAX = 64'hffff000000000000;

endpackage : tpm_gate_pkg

// [fw_block_check.sv]
// firmware update block sequence and integrity checker
`timescale 1ns/1ps
`default_nettype none
module fw_block_check #(
    parameter int SEQ_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic blk_valid_i,
    input wire logic [SEQ_W-1:0] seq_i,
    input wire logic mac_ok_i,
    input wire logic last_i,
    output logic blk_ok_o,
    output logic blk_done_o
);

    logic [SEQ_W-1:0] exp_r;

    // mac catches modification, sequence catches deletion, insertion, replay
    assign blk_ok_o = blk_valid_i && mac_ok_i && (seq_i == exp_r);
    assign blk_done_o = blk_ok_o && last_i;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            exp_r <= '0;
        end else if (start_i) begin
            exp_r <= '0;
        end else if (blk_ok_o) begin
            exp_r <= exp_r + 1'b1;
        end
    end

    AST_FW_SEQ_ADV: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (blk_valid_i && !start_i && (seq_i != exp_r)) |=> (exp_r == $past(exp_r)))
        else $error("expected sequence moved on a bad block");

endmodule : fw_block_check
`default_nettype wire

// [selftest_engine_model.sv]
// self-test engine model answering the latest start after a fixed delay
`timescale 1ns/1ps
`default_nettype none
module selftest_engine_model #(
    parameter int DLY = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic pass_i,
    output logic done_o,
    output logic pass_o
);
    int cnt_r;
    // countdown to the done pulse, a new start restarts it
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) cnt_r <= 0;
        else if (start_i) cnt_r <= DLY;
        else if (cnt_r > 0) cnt_r <= cnt_r - 1;
    end
    // result held only with done, inverted otherwise
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_o <= 1'h0;
            pass_o <= 1'h0;
        end else begin
            done_o <= (cnt_r == 1);
            pass_o <= (cnt_r == 1) ? pass_i : ~pass_i;
        end
    end
endmodule : selftest_engine_model
`default_nettype wire

// [test_tpm_state_gate.sv]
// bench for the state and command gate
`timescale 1ns/1ps
`default_nettype none
module test_tpm_state_gate;
    import tpm_gate_pkg::*;
    logic ref_clk_i = 1'h0, rst_n_i = 1'h0, cmd_valid_i = 1'h0, cmd_su_type_i = 1'h0, cmd_untested_i = 1'h0;
    logic sess_load_i = 1'h0, pp_req_i = 1'h0, pp_i = 1'h0, key_sign_ext_i = 1'h0, key_enc_ext_i = 1'h0;
    logic key_dec_ext_i = 1'h0, fw_sig_ok_i = 1'h0, fw_mac_ok_i = 1'h0, fw_last_i = 1'h0, restore_ok_i = 1'h0;
    logic init_ind_i = 1'h0, eng_pass = 1'h1, st_done_i, st_pass_i, rsp_valid_o, exec_o, st_start_o;
    logic opvar_reset_o, saved_valid_o, fw_import_o;
    logic [2:0] side_exp = 3'h0;
    logic [ROLE_W-1:0] sess_roles_i = 3'h0, sess_roles_o;
    logic [CLK_W-1:0] clk_new_i = 64'h0, clk_cur_i = 64'h0;
    logic [15:0] fw_seq_i = 16'h0;
    logic [RC_W-1:0] rsp_code_o;
    cmd_e cmd_code_i = CMD_OTHER;
    gate_state_e state_o;
    int miscompares = 0, checked = 0;
    cmd_e ops[19] = '{CMD_EVICT_CONTROL, CMD_CLOCK_SET, CMD_CLOCK_RATE_ADJ, CMD_READ_CLOCK, CMD_SIGN, CMD_RSA_ENC,
        CMD_RSA_DEC, CMD_ECDH_ZGEN, CMD_HMAC_START, CMD_HASH_SEQ_START, CMD_SEQ_UPDATE, CMD_SEQ_COMPLETE,
        CMD_EVENT_SEQ_COMPLETE, CMD_VERIFY_SIG, CMD_GET_RANDOM, CMD_STIR_RANDOM, CMD_ECDH_KEYGEN, CMD_ECC_PARAMS,
        CMD_HASH};

    tpm_state_gate uut (.ref_clk_i, .rst_n_i, .cmd_valid_i, .cmd_code_i, .cmd_su_type_i, .cmd_untested_i,
        .sess_load_i, .sess_roles_i, .pp_req_i, .pp_i, .key_sign_ext_i, .key_enc_ext_i, .key_dec_ext_i,
        .clk_new_i, .clk_cur_i, .fw_sig_ok_i, .fw_seq_i, .fw_mac_ok_i, .fw_last_i, .restore_ok_i, .init_ind_i,
        .st_done_i, .st_pass_i, .rsp_valid_o, .rsp_code_o, .exec_o, .state_o, .st_start_o, .opvar_reset_o,
        .saved_valid_o, .fw_import_o, .sess_roles_o);
    selftest_engine_model eng (.clk_i(ref_clk_i), .rst_n_i(rst_n_i), .start_i(st_start_o), .pass_i(eng_pass),
        .done_o(st_done_i), .pass_o(st_pass_i));

    initial begin
        forever #25 ref_clk_i = ~ref_clk_i;
    end

    task automatic chk(input string nm, input logic [RC_W-1:0] exp, input logic [RC_W-1:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic chk_st(input gate_state_e exp);
        checked++;
        if (state_o !== exp) begin
            miscompares++;
            $display("MISMATCH state expected %s seen %s", exp.name(), state_o.name());
        end
    endtask : chk_st

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test

    // one command, response checked one cycle later; rc ff skips the code
    task automatic cmd(input cmd_e c, input logic [RC_W-1:0] rc, input logic ex);
        cmd_code_i = c;
        cmd_valid_i = 1'h1;
        @(negedge ref_clk_i);
        cmd_valid_i = 1'h0;
        chk("rsp_valid", 8'h1, {7'h0, rsp_valid_o});
        chk("exec", {7'h0, ex}, {7'h0, exec_o});
        chk("pulses", {5'h0, side_exp}, {5'h0, opvar_reset_o, fw_import_o, st_start_o});
        if (rc !== 8'hff) chk("rsp_code", rc, rsp_code_o);
        @(negedge ref_clk_i);
    endtask : cmd

    task automatic wait_ev(input logic by_state, input gate_state_e s);
        int n = 0;
        while ((by_state ? state_o !== s : st_done_i !== 1'h1) && n < 100) begin
            @(negedge ref_clk_i);
            n++;
        end
        if (n >= 100) begin
            chk("wait", 8'h0, 8'h1);
            end_of_test();
        end
        @(negedge ref_clk_i);
    endtask : wait_ev

    task automatic load(input logic [ROLE_W-1:0] r);
        sess_roles_i = r;
        sess_load_i = 1'h1;
        @(negedge ref_clk_i);
        sess_load_i = 1'h0;
        chk("roles", {5'h0, r}, {5'h0, sess_roles_o});
    endtask : load

    task automatic pulse_init();
        init_ind_i = 1'h1;
        @(negedge ref_clk_i);
        init_ind_i = 1'h0;
        chk_st(ST_INIT);
        wait_ev(1'h0, ST_INIT);
    endtask : pulse_init

    task automatic go_oper();
        cmd_su_type_i = SU_CLEAR;
        side_exp = 3'h4;
        cmd(CMD_STARTUP, RC_SUCCESS, 1'h1);
        side_exp = 3'h0;
        chk_st(ST_OPER);
    endtask : go_oper

    task automatic blk(input logic [15:0] sq, input logic mac, input logic last, input logic [RC_W-1:0] rc);
        fw_seq_i = sq;
        fw_mac_ok_i = mac;
        fw_last_i = last;
        side_exp = {1'h0, rc == RC_SUCCESS, 1'h0};
        cmd(CMD_FW_DATA, rc, rc == RC_SUCCESS);
        side_exp = 3'h0;
    endtask : blk

    function automatic logic [RC_W-1:0] exp_rc(input cmd_e c, input logic [ROLE_W-1:0] r);
        logic po;
        logic u;
        po = (r[ROLE_PLAT] & (~pp_req_i | pp_i)) | r[ROLE_OWNER];
        u = r[ROLE_USER];
        case (c)
            CMD_EVICT_CONTROL, CMD_CLOCK_RATE_ADJ: return po ? RC_SUCCESS : RC_AUTH_FAIL;
            CMD_CLOCK_SET: return !po ? RC_AUTH_FAIL :
                (clk_new_i < clk_cur_i || clk_new_i > CLK_MAX) ? RC_VALUE : RC_SUCCESS;
            CMD_SIGN: return !u ? RC_AUTH_FAIL : key_sign_ext_i ? RC_SUCCESS : RC_ATTRIBUTES;
            CMD_RSA_DEC: return !u ? RC_AUTH_FAIL : key_dec_ext_i ? RC_SUCCESS : RC_ATTRIBUTES;
            CMD_RSA_ENC: return key_enc_ext_i ? RC_SUCCESS : RC_ATTRIBUTES;
            CMD_ECDH_ZGEN, CMD_HMAC_START, CMD_SEQ_UPDATE, CMD_SEQ_COMPLETE, CMD_EVENT_SEQ_COMPLETE:
                return u ? RC_SUCCESS : RC_AUTH_FAIL;
            default: return RC_SUCCESS;
        endcase
    endfunction : exp_rc

    initial begin
        int k;
        cmd_e c;
        logic [RC_W-1:0] e;
        void'($urandom(32'h383f));
        repeat (12) @(negedge ref_clk_i);
        chk_st(ST_INIT);
        chk("roles", 8'h0, {5'h0, sess_roles_o});
        rst_n_i = 1'h1;
        @(negedge ref_clk_i);
        chk("st_start", 8'h1, {7'h0, st_start_o});
        cmd(CMD_GET_CAP, RC_TESTING, 1'h0);
        wait_ev(1'h0, ST_INIT);
        cmd_su_type_i = SU_STATE;
        cmd(CMD_STARTUP, RC_FAILURE, 1'h0);
        chk_st(ST_INIT);
        for (int i = 0; i < 15; i++)
            if (i < 5 || i > 7) cmd(cmd_e'(i), RC_SUCCESS, 1'h1);
        repeat (8) cmd(cmd_e'($urandom_range(30, 16)), RC_INITIALIZE, 1'h0);
        side_exp = 3'h1;
        cmd(CMD_SELF_TEST, RC_SUCCESS, 1'h1);
        side_exp = 3'h0;
        cmd(CMD_GET_CAP, RC_TESTING, 1'h0);
        wait_ev(1'h0, ST_INIT);
        cmd(CMD_SHUTDOWN, RC_SUCCESS, 1'h1);
        chk("saved", 8'h1, {7'h0, saved_valid_o});
        restore_ok_i = 1'h1;
        cmd(CMD_STARTUP, RC_SUCCESS, 1'h1);
        chk_st(ST_OPER);
        cmd(CMD_STARTUP, RC_INITIALIZE, 1'h0);
        cmd(CMD_SHUTDOWN, RC_SUCCESS, 1'h1);
        chk("saved", 8'h1, {7'h0, saved_valid_o});
        pulse_init();
        restore_ok_i = 1'h0;
        cmd(CMD_STARTUP, RC_FAILURE, 1'h0);
        chk_st(ST_FAIL);
        cmd(CMD_GET_TEST_RESULT, RC_SUCCESS, 1'h1);
        cmd(CMD_GET_CAP, RC_SUCCESS, 1'h1);
        cmd(CMD_READ_CLOCK, RC_FAILURE, 1'h0);
        pulse_init();
        go_oper();
        for (int i = 0; i < 80; i++) begin
            {key_sign_ext_i, key_enc_ext_i, key_dec_ext_i, pp_i, pp_req_i} = 5'($urandom);
            k = $urandom_range(3, 0);
            clk_cur_i = {24'h0, $urandom, 8'h0};
            clk_new_i = (k == 0) ? clk_cur_i - 64'h1 : (k == 1) ? clk_cur_i : CLK_MAX + {63'h0, k[0]};
            load(3'($urandom));
            c = ops[$urandom_range(18, 0)];
            e = exp_rc(c, sess_roles_i);
            cmd(c, e, e === RC_SUCCESS);
        end
        for (int i = 0; i < 2; i++) begin
            side_exp = 3'h1;
            cmd(i ? CMD_INCR_SELF_TEST : CMD_SELF_TEST, RC_SUCCESS, 1'h1);
            side_exp = 3'h0;
            chk_st(ST_SELFTEST);
            cmd(CMD_HASH, RC_TESTING, 1'h0);
            wait_ev(1'h1, ST_OPER);
        end
        cmd_untested_i = 1'h1;
        eng_pass = 1'h0;
        side_exp = 3'h1;
        cmd(CMD_SIGN, RC_TESTING, 1'h0);
        side_exp = 3'h0;
        cmd_untested_i = 1'h0;
        wait_ev(1'h1, ST_FAIL);
        eng_pass = 1'h1;
        pulse_init();
        go_oper();
        load(3'h1);
        cmd(CMD_FW_START, 8'hff, 1'h0);
        chk_st(ST_OPER);
        fw_sig_ok_i = 1'h1;
        cmd(CMD_FW_START, RC_SUCCESS, 1'h1);
        chk_st(ST_FWUPD);
        blk(16'h1, 1'h1, 1'h0, RC_INTEGRITY);
        blk(16'h0, 1'h0, 1'h0, RC_INTEGRITY);
        blk(16'h0, 1'h1, 1'h0, RC_SUCCESS);
        blk(16'h0, 1'h1, 1'h0, RC_INTEGRITY);
        cmd(CMD_GET_RANDOM, RC_FAILURE, 1'h0);
        chk_st(ST_FWUPD);
        blk(16'h1, 1'h1, 1'h1, RC_SUCCESS);
        chk_st(ST_INIT);
        rst_n_i = 1'h0;
        @(negedge ref_clk_i);
        chk("roles", 8'h0, {5'h0, sess_roles_o});
        chk_st(ST_INIT);
        end_of_test();
    end
endmodule : test_tpm_state_gate
`default_nettype wire
